/* File: port_c_pin_function_direction.sv */
// port c direction and function select registers with apb slave and pin mux
`timescale 1ns/1ps
`include "port_c_defines.svh"
// Notes on behaviour
// - 16-bit direction register; bit n set makes pin n output, clear makes input.
// - direction bit acts only while pin is general input/output.
// - direction register clears to zero on external power-on reset.
// - direction register holds through manual, watchdog resets, standby, sleep.
// - 16-bit function-select register, all bits read/write, bit n for pin n.
// - function bit 0 is general input/output, 1 drives address bit n.
// - single-chip mode keeps every pin general input/output regardless.
// - rom disabled drives address bit even when function bit is 0.
// - function-select register clears to zero on power-on reset.
// - function-select register holds through manual, watchdog resets, standby, sleep.
module port_c_pin_function_direction
  import port_c_pkg::*;
#(
  parameter int PINS = `PORT_C_REG_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PORT_C_ADDR_WIDTH-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] chip_mode,
  input wire logic [PINS-1:0] gpio_out,
  input wire logic [PINS-1:0] external_address,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output logic [PINS-1:0] gpio_in
);
  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // presetn is the power-on reset only; manual/watchdog resets and
  // low-power states must not reach it, so the registers keep their data
  logic [PINS-1:0] port_c_direction_reg;
  logic [PINS-1:0] port_c_direction_next;
  logic [PINS-1:0] port_c_function_reg;
  logic [PINS-1:0] port_c_function_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pslverr_reg;
  logic [PINS-1:0] address_mode;
  wire logic setup_phase;
  wire logic access_phase;
  wire logic sel_dir;
  wire logic sel_fun;
  wire logic sel_sts;
  wire logic mapped;
  wire logic wr_dir;
  wire logic wr_fun;
  wire logic [PINS-1:0] lane_mask;
  wire logic single_chip;
  wire logic rom_disabled;
  wire logic [31:0] read_mux;

  apb_phase_t apb_phase_reg;
  apb_phase_t apb_phase_next;
  chip_mode_t mode_now;
  logic [`PORT_C_ADDR_WIDTH-1:0] setup_addr_reg;
  logic [`PORT_C_ADDR_WIDTH-1:0] setup_addr_next;
  logic setup_write_reg;
  logic setup_write_next;
  wire logic request_steady;
  wire logic access_ok;

  wire logic [PINS-1:0] direction_merged;
  wire logic [PINS-1:0] function_merged;
  wire logic [31:0] direction_word;
  wire logic [31:0] function_word;
  wire logic [31:0] status_word;
  wire logic read_setup;
  wire logic err_unmapped;
  wire logic err_status_write;
  wire logic pslverr_next;

  assign setup_phase = psel && !penable;
  // a master that moves address or direction between setup and access
  // gets no write; only the request it set up is honoured
  assign request_steady = (paddr == setup_addr_reg) && (pwrite == setup_write_reg);
  // an access only counts right after a setup cycle, so a penable left
  // high cannot write twice
  assign access_ok = (apb_phase_reg == APB_SETUP) && request_steady;
  assign access_phase = psel && penable && access_ok;
  assign sel_dir = (paddr == `PORT_C_DIRECTION_OFFSET);
  assign sel_fun = (paddr == `PORT_C_FUNCTION_OFFSET);
  assign sel_sts = (paddr == `PORT_C_STATUS_OFFSET);
  assign mapped = sel_dir || sel_fun || sel_sts;
  assign wr_dir = access_phase && pwrite && sel_dir;
  assign wr_fun = access_phase && pwrite && sel_fun;
  // one strobe per byte lane of the register
  genvar lane;
  generate
    for (lane = 0; lane < PINS / 8; lane++) begin : g_lane
      assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
    end
  endgenerate
  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ----------------------------------------
  // apb phase tracker
  // ----------------------------------------
  // remembers which phase the last edge saw; pready is always high,
  // so an access never stretches beyond one cycle
  always_comb begin
    apb_phase_next = APB_IDLE;
    case (apb_phase_reg)
      APB_IDLE: begin
        if (psel && !penable) begin
          apb_phase_next = APB_SETUP;
        end
      end

      APB_SETUP: begin
        if (psel && penable) begin
          apb_phase_next = APB_ACCESS;
        end else if (psel) begin
          apb_phase_next = APB_SETUP;
        end
      end

      APB_ACCESS: begin
        if (psel && !penable) begin
          apb_phase_next = APB_SETUP;
        end
      end

      default: begin
        apb_phase_next = APB_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // setup capture
  // ----------------------------------------
  assign setup_addr_next = setup_phase ? paddr : setup_addr_reg;
  assign setup_write_next = setup_phase ? pwrite : setup_write_reg;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // code 2'b11 is unused and behaves like the rom-enabled expanded mode
  assign mode_now = chip_mode_t'(chip_mode);
  assign single_chip = (mode_now == MODE_SINGLE_CHIP);
  assign rom_disabled = (mode_now == MODE_ROM_DISABLED);

  // ----------------------------------------
  // register next values
  // ----------------------------------------
  // strobed lanes take the new byte, the other lane keeps its old value
  assign direction_merged = (port_c_direction_reg & ~lane_mask) | (pwdata[PINS-1:0] & lane_mask);
  assign function_merged = (port_c_function_reg & ~lane_mask) | (pwdata[PINS-1:0] & lane_mask);
  assign port_c_direction_next = wr_dir ? direction_merged : port_c_direction_reg;
  assign port_c_function_next = wr_fun ? function_merged : port_c_function_reg;

  // ----------------------------------------
  // read path
  // ----------------------------------------
  // upper half reads zero; the registers are only 16 bits wide
  assign direction_word = {16'h0000, port_c_direction_reg};
  assign function_word = {16'h0000, port_c_function_reg};
  // status word: resolved address-mode pins, read only
  assign status_word = {16'h0000, address_mode};
  assign read_mux = sel_dir ? direction_word :
                    sel_fun ? function_word :
                    sel_sts ? status_word : 32'h00000000;
  assign read_setup = setup_phase && !pwrite;
  // captured in setup so the data stands through the whole access cycle
  assign prdata_next = read_setup ? read_mux : prdata_reg;

  // ----------------------------------------
  // error path
  // ----------------------------------------
  assign err_unmapped = !mapped;
  assign err_status_write = sel_sts && pwrite;
  // error is flagged in the access cycle of an unmapped read or write, or of a status write
  assign pslverr_next = setup_phase && (err_unmapped || err_status_write);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // direction bits: only the power-on reset clears them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_direction_reg <= `PORT_C_DIRECTION_RESET;
    end else begin
      port_c_direction_reg <= port_c_direction_next;
    end
  end

  // function-select bits: same reset source as the direction bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_c_function_reg <= `PORT_C_FUNCTION_RESET;
    end else begin
      port_c_function_reg <= port_c_function_next;
    end
  end

  // ----------------------------------------
  // bus side registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_reg <= 1'b0;
    end else begin
      pslverr_reg <= pslverr_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      apb_phase_reg <= APB_IDLE;
    end else begin
      apb_phase_reg <= apb_phase_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_addr_reg <= 12'h000;
      setup_write_reg <= 1'b0;
    end else begin
      setup_addr_reg <= setup_addr_next;
      setup_write_reg <= setup_write_next;
    end
  end

  // ----------------------------------------
  // pin cells
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < PINS; i++) begin : g_pin
      port_c_pin_cell u_cell (
        .direction_bit(port_c_direction_reg[i]),
        .function_bit(port_c_function_reg[i]),
        .single_chip(single_chip),
        .rom_disabled(rom_disabled),
        .gpio_out(gpio_out[i]),
        .external_address_bit(external_address[i]),
        .pin_in(pin_in[i]),
        .pin_out(pin_out[i]),
        .pin_oe(pin_oe[i]),
        .gpio_in(gpio_in[i]),
        .address_mode(address_mode[i])
      );
    end
  endgenerate
endmodule : port_c_pin_function_direction

/* File: port_c_defines.svh */
// register offsets, reset values and field widths for the port c pin function block
`ifndef PORT_C_DEFINES_SVH
`define PORT_C_DEFINES_SVH
`define PORT_C_DIRECTION_OFFSET 12'h000
`define PORT_C_FUNCTION_OFFSET 12'h004
`define PORT_C_STATUS_OFFSET 12'h008
`define PORT_C_DIRECTION_RESET 16'h0000
`define PORT_C_FUNCTION_RESET 16'h0000
`define PORT_C_REG_WIDTH 16
`define PORT_C_ADDR_WIDTH 12
`endif

/* File: port_c_pkg.sv */
// types for the port c pin function block
package port_c_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE_CHIP = 2'b00,
    MODE_ROM_ENABLED = 2'b01,
    MODE_ROM_DISABLED = 2'b10
  } chip_mode_t;
  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_SETUP = 2'b01,
    APB_ACCESS = 2'b10
  } apb_phase_t;
endpackage : port_c_pkg

/* File: port_c_pin_cell.sv */
// one pin of port c: function resolution and output drive
`timescale 1ns/1ps
module port_c_pin_cell (
  input wire logic direction_bit,
  input wire logic function_bit,
  input wire logic single_chip,
  input wire logic rom_disabled,
  input wire logic gpio_out,
  input wire logic external_address_bit,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic gpio_in,
  output logic address_mode
);
  // ----------------------------------------
  // function resolution
  // ----------------------------------------
  // single chip wins over rom-disabled: no address bus exists at all
  wire logic addr_sel;
  assign addr_sel = !single_chip && (function_bit || rom_disabled);
  assign address_mode = addr_sel;
  // ----------------------------------------
  // drive
  // ----------------------------------------
  assign pin_out = addr_sel ? external_address_bit : gpio_out;
  assign pin_oe = addr_sel ? 1'b1 : direction_bit;
  assign gpio_in = pin_in;
endmodule : port_c_pin_cell

/* File: port_c_checker_assertions.sv */
// concurrent checks on the port c pin function block ports
`timescale 1ns/1ps
module port_c_checker #(
  parameter int PINS = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic [3:0] pstrb,
  input wire logic [1:0] chip_mode,
  input wire logic [PINS-1:0] gpio_out,
  input wire logic [PINS-1:0] external_address,
  input wire logic [PINS-1:0] pin_in,
  input wire logic [PINS-1:0] pin_out,
  input wire logic [PINS-1:0] pin_oe,
  input wire logic [PINS-1:0] gpio_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wa = psel && penable && pwrite;
  wire wf = wa && pstrb[1:0] == 2'b11;
  a_single_chip: assert property (chip_mode == 2'b00 |-> pin_out == gpio_out)
    else $error("pin left gpio in single chip");
  a_rom_off: assert property (chip_mode == 2'b10 |-> pin_out == external_address && pin_oe == '1)
    else $error("address not driven with rom off");
  a_dir_write: assert property (wf && paddr == 12'h000 && chip_mode == 2'b00 ##1 chip_mode == 2'b00
    |-> pin_oe == $past(pwdata[15:0])) else $error("direction write not seen");
  a_func_write: assert property (wf && paddr == 12'h004 && chip_mode == 2'b01 ##1 chip_mode == 2'b01
    |-> (pin_oe & $past(pwdata[15:0])) == $past(pwdata[15:0])) else $error("address pin not driving");
  a_dir_hold: assert property (!wa && chip_mode == 2'b00 ##1 chip_mode == 2'b00 |-> $stable(pin_oe))
    else $error("direction changed without write");
  a_func_hold: assert property (!wa && chip_mode == 2'b01 ##1 chip_mode == 2'b01 |-> $stable(pin_oe))
    else $error("function changed without write");
  a_reset_clear: assert property (disable iff (1'b0) $rose(presetn) && chip_mode != 2'b10 |-> pin_oe == '0)
    else $error("pins not inputs after reset");
  a_mapped_ok: assert property (psel && penable && paddr inside {12'h000, 12'h004} |-> !pslverr)
    else $error("error on mapped register");
  cover property (wf && paddr == 12'h004);
  cover property (chip_mode == 2'b10);
  cover property (psel && penable && pslverr);
  cover property (chip_mode == 2'b11 && psel && penable);
endmodule : port_c_checker
bind port_c_pin_function_direction port_c_checker #(.PINS(PINS)) port_c_checker_i (.*);

/* File: port_c_pins_model.sv */
// model of the devices on the port c pins
`timescale 1ns/1ps
module port_c_pins_model (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  output logic [15:0] pin_in
);
  // no pull: a released pin shows the inverse, so a wrong input source shows
  assign pin_in = (pin_out & pin_oe) | (~pin_out & ~pin_oe);
endmodule : port_c_pins_model

/* File: test_port_c_pin_function_direction.sv */
// self-checking testbench for the port c pin function block
`timescale 1ns/1ps
module test_port_c_pin_function_direction;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h3;
  logic [1:0] chip_mode = 2'b00;
  logic [15:0] gpio_out = 16'h1234, external_address = 16'hc3a5, pin_in, pin_out, pin_oe, gpio_in;
  int errors = 0, checks_done = 0;
  port_c_pin_function_direction port_c_pin_function_direction_i (.*);
  port_c_pins_model port_c_pins_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
  initial forever #4 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // hold the request until pready is seen at an edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : xfer
  task automatic t_reset;
    xfer(0, 12'h000, 0); chk(rd, 0);
    xfer(0, 12'h004, 0); chk(rd, 0);
    chk(pin_oe, 0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_dir;
    xfer(1, 12'h000, 32'ha5c3);
    xfer(1, 12'h004, 32'hffff);
    chk(pin_oe, 16'ha5c3);
    chk(pin_out, gpio_out);
    chk(gpio_in, 16'((gpio_out & 16'ha5c3) | (~gpio_out & ~16'ha5c3)));
    xfer(0, 12'h000, 0); chk(rd, 32'ha5c3);
    $display("direction test done");
  endtask : t_dir
  task automatic t_func;
    chip_mode <= 2'b01;
    xfer(1, 12'h004, 32'h00ff);
    chk(pin_oe, 16'ha5ff);
    chk(pin_out, (external_address & 16'h00ff) | (gpio_out & 16'hff00));
    xfer(0, 12'h008, 0); chk(rd, 32'h00ff);
    chip_mode <= 2'b10;
    @(posedge pclk);
    chk(pin_oe, 16'hffff);
    chk(pin_out, external_address);
    $display("function test done");
  endtask : t_func
  task automatic t_err;
    xfer(1, 12'h010, 32'hffff); chk(er, 1);
    xfer(0, 12'h010, 0); chk(rd, 0);
    xfer(1, 12'h008, 32'h0); chk(er, 1);
    repeat (5) @(posedge pclk);
    xfer(0, 12'h004, 0); chk(rd, 32'h00ff);
    xfer(0, 12'h000, 0); chk(rd, 32'ha5c3);
    $display("refusal test done");
  endtask : t_err
  task automatic t_late;
    chip_mode <= 2'b11;
    pstrb <= 4'h1;
    xfer(1, 12'h000, 32'h0f0f);
    pstrb <= 4'h3;
    xfer(0, 12'h000, 0); chk(rd, 32'ha50f);
    chk(pin_oe, 16'ha5ff);
    chk(pin_out, (external_address & 16'h00ff) | (gpio_out & 16'hff00));
    chip_mode <= 2'b00;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk(pin_oe, 0);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, 12'h004, 0); chk(rd, 0);
    xfer(0, 12'h000, 0); chk(rd, 0);
    $display("strobe and reset test done");
  endtask : t_late
  task automatic results;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : results
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_dir;
    t_func;
    t_err;
    t_late;
    results;
  end
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule : test_port_c_pin_function_direction
